// ### verilog/rlp_pkg.sv
// Package: register map, field layout, reset values of the sleep/mask bank.
package rlp_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_W = 16;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_SLEEP_CFG = 8'hD3;
  localparam logic [7:0] IDX_FAULT_MASK = 8'hD7;
  localparam logic [7:0] IDX_BANDGAP = 8'hD8;
  localparam logic [7:0] IDX_OSC = 8'hD9;
  localparam logic [7:0] IDX_UNLOCK_KEY = 8'hDB;
  localparam logic [7:0] IDX_HIB_CTRL = 8'hF0;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF2;
  localparam logic [7:0] IDX_FAULT_STAT = 8'hF3;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned SLP_MODE_LSB = 12;
  localparam int unsigned SLP_TRIG_LSB = 8;
  localparam int unsigned SLP_VCODE_LSB = 0;
  localparam logic [1:0] SLP_MODE_RST = 2'h0;
  localparam logic [1:0] SLP_TRIG_RST = 2'h0;
  localparam logic [4:0] SLP_VCODE_RST = 5'h1C;
  localparam logic [1:0] MODE_VOLT_IMAGE = 2'h0;
  localparam logic [1:0] MODE_OUTPUT_OFF = 2'h1;
  localparam logic [1:0] TRIG_HIB_BIT = 2'h0;
  localparam int unsigned MASK_LS_BIT = 15;
  localparam int unsigned MASK_LIN_LSB = 8;
  localparam int unsigned MASK_CONV_LSB = 0;
  localparam logic [15:0] MASK_VALID = 16'h8F3F;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam int unsigned FUSE_LOAD_BIT = 15;
  localparam logic [15:0] KEY_RST = 16'h0000;
  localparam logic [15:0] UNLOCK_VALUE = 16'h0013;

  // ****************************************************************
  // Interrupt layout and input synchroniser width
  // ****************************************************************
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_HIB = 1;
  localparam int unsigned IRQ_BG_LATCH = 2;
  localparam int unsigned IRQ_OSC_LATCH = 3;
  localparam int unsigned IRQ_LOCKED = 4;
  localparam int unsigned SYNC_W = 19;

endpackage : rlp_pkg

// ### verilog/rlp_sync_if.sv
// Interface: raw pin levels in, synchronised levels out.
`timescale 1ns/1ps
interface rlp_sync_if;
  import rlp_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] synced;
  modport user (output raw, input synced);
  modport syncer (input raw, output synced);
endinterface : rlp_sync_if

// ### verilog/rlp_sync.sv
// Module: two-flop synchroniser for the asynchronous pin inputs.
`timescale 1ns/1ps
module rlp_sync (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  rlp_sync_if.syncer bus
);
  import rlp_pkg::*;

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  // The first stage feeds only the second; nothing else may look at it.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // Two flops per pin, frozen with the clock enable like all state.
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (ce_i) begin
          meta_q <= bus.raw[gi];
          sync_q <= meta_q;
        end
      end
      assign bus.synced[gi] = sync_q;
    end
  endgenerate

endmodule : rlp_sync

// ### verilog/rlp_regs.sv
// Module: regulator-4 sleep, supply-fault mask and fuse-load register bank.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Sleep behaviour 00 uses sleep voltage code, 01 turns regulator off.
// - Trigger select 00 hibernate bit, 01/10/11 low-power inputs one..three.
// - Five-bit sleep voltage code, default 1_1100, passed to regulator.
// - Power state machine reset restores sleep fields to fixed defaults.
// - Mask bit 0 lets the supply fault through, 1 blocks it.
// - Limit switch fault mask sits at bit 15.
// - Linear regulator one to four masks sit at bits 8 to 11.
// - Converter one to six masks sit at bits 0 to 5.
// - Power state machine reset clears every fault mask bit.
// - Bandgap control bit 15 powers the trim fuses; software holds it.
// - Oscillator bit 15 is a fuse-load control like the bandgap one.
// - Oscillator fuse-load writes ignored unless security unlock done.
// - Locked writes accepted only while the key register holds 0013h.
module rlp_regs (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psm_reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rlp_pkg::APB_AW-1:0] paddr_i,
  input wire logic [rlp_pkg::APB_DW-1:0] pwdata_i,
  output logic [rlp_pkg::APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [rlp_pkg::REG_W-1:0] supply_fault_i,
  input wire logic low_power_input_one_i,
  input wire logic low_power_input_two_i,
  input wire logic low_power_input_three_i,
  output logic supply_fault_n_o,
  output logic reg4_sleep_o,
  output logic reg4_use_sleep_voltage_o,
  output logic reg4_output_off_o,
  output logic [4:0] reg4_sleep_voltage_code_o,
  output logic bandgap_fuse_load_o,
  output logic bandgap_trim_latch_o,
  output logic osc_fuse_load_o,
  output logic osc_trim_latch_o,
  output logic irq_o
);
  import rlp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rlp_sync_if sync_bus ();
  logic [1:0] sleep_mode_q;
  logic [1:0] sleep_trig_q;
  logic [4:0] sleep_vcode_q;
  logic [REG_W-1:0] fault_mask_q;
  logic bg_load_q;
  logic osc_load_q;
  logic [REG_W-1:0] key_q;
  logic hib_bit_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_event;
  logic irq_q;
  logic [APB_DW-1:0] prdata_q;
  logic slverr_q;
  logic fault_n_q;
  logic sleep_q;
  logic use_vimg_q;
  logic off_q;
  logic bg_latch_q;
  logic osc_latch_q;
  logic [REG_W-1:0] fault_sync;
  logic [2:0] lp_sync;
  logic [7:0] idx;
  logic hit;
  logic sel_cfg, sel_mask, sel_bg, sel_osc, sel_key;
  logic sel_hib, sel_stat, sel_imask, sel_fstat;
  logic wr_acc;
  logic unlocked;
  logic osc_refused;
  logic bg_latch_d;
  logic osc_latch_d;
  logic hib_now;
  logic fault_active;
  logic [REG_W-1:0] rdata;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Faults and low-power pins come from outside the clock domain.
  assign sync_bus.raw = {low_power_input_three_i, low_power_input_two_i,
                         low_power_input_one_i, supply_fault_i};
  assign fault_sync = sync_bus.synced[REG_W-1:0];
  assign lp_sync = sync_bus.synced[SYNC_W-1:REG_W];

  rlp_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .bus (sync_bus.syncer)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Only word-aligned addresses inside the low kilobyte are mapped.
  assign idx = paddr_i[9:2];

  always_comb begin
    sel_cfg = 1'b0;
    sel_mask = 1'b0;
    sel_bg = 1'b0;
    sel_osc = 1'b0;
    sel_key = 1'b0;
    sel_hib = 1'b0;
    sel_stat = 1'b0;
    sel_imask = 1'b0;
    sel_fstat = 1'b0;
    hit = 1'b1;
    if ((paddr_i[1:0] != 2'h0) || (paddr_i[11:10] != 2'h0)) begin
      hit = 1'b0;
    end else if (idx == IDX_SLEEP_CFG) begin
      sel_cfg = 1'b1;
    end else if (idx == IDX_FAULT_MASK) begin
      sel_mask = 1'b1;
    end else if (idx == IDX_BANDGAP) begin
      sel_bg = 1'b1;
    end else if (idx == IDX_OSC) begin
      sel_osc = 1'b1;
    end else if (idx == IDX_UNLOCK_KEY) begin
      sel_key = 1'b1;
    end else if (idx == IDX_HIB_CTRL) begin
      sel_hib = 1'b1;
    end else if (idx == IDX_IRQ_STAT) begin
      sel_stat = 1'b1;
    end else if (idx == IDX_IRQ_MASK) begin
      sel_imask = 1'b1;
    end else if (idx == IDX_FAULT_STAT) begin
      sel_fstat = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Writes land in the access phase; the slave never inserts wait states.
  assign wr_acc = psel_i & penable_i & pwrite_i & hit;
  assign pready_o = 1'b1;
  assign unlocked = (key_q == UNLOCK_VALUE);
  assign osc_refused = wr_acc & sel_osc & ~unlocked;

  // ****************************************************************
  // Regulator-4 sleep configuration
  // ****************************************************************
  // State machine reset beats a write in the same cycle.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_mode_q <= SLP_MODE_RST;
      sleep_trig_q <= SLP_TRIG_RST;
      sleep_vcode_q <= SLP_VCODE_RST;
    end else if (ce_i) begin
      if (psm_reset_i) begin
        sleep_mode_q <= SLP_MODE_RST;
        sleep_trig_q <= SLP_TRIG_RST;
        sleep_vcode_q <= SLP_VCODE_RST;
      end else if (wr_acc && sel_cfg) begin
        // Reserved behaviour codes are kept as written.
        sleep_mode_q <= pwdata_i[SLP_MODE_LSB +: 2];
        sleep_trig_q <= pwdata_i[SLP_TRIG_LSB +: 2];
        sleep_vcode_q <= pwdata_i[SLP_VCODE_LSB +: 5];
      end
    end
  end

  // ****************************************************************
  // Supply-fault masks
  // ****************************************************************
  // Unused mask positions are not stored and read as zero.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fault_mask_q <= MASK_RST;
    end else if (ce_i) begin
      if (psm_reset_i) begin
        fault_mask_q <= MASK_RST;
      end else if (wr_acc && sel_mask) begin
        fault_mask_q <= pwdata_i[REG_W-1:0] & MASK_VALID;
      end
    end
  end

  // ****************************************************************
  // Unlock key, hibernate bit and fuse-load controls
  // ****************************************************************
  // The key stays valid until overwritten or cleared by state machine reset, so a sequence of locked
  // writes needs only one unlock.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      key_q <= KEY_RST;
      hib_bit_q <= 1'b0;
    end else if (ce_i) begin
      if (psm_reset_i) begin
        key_q <= KEY_RST;
        hib_bit_q <= 1'b0;
      end else begin
        if (wr_acc && sel_key) begin
          key_q <= pwdata_i[REG_W-1:0];
        end
        if (wr_acc && sel_hib) begin
          hib_bit_q <= pwdata_i[0];
        end
      end
    end
  end

  // A falling load bit marks the moment the fused trim is captured.
  assign bg_latch_d = wr_acc & sel_bg & bg_load_q
                      & ~pwdata_i[FUSE_LOAD_BIT];
  assign osc_latch_d = wr_acc & sel_osc & unlocked & osc_load_q
                       & ~pwdata_i[FUSE_LOAD_BIT];

  // Fuse current follows the stored bit for as long as software holds it.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bg_load_q <= 1'b0;
      osc_load_q <= 1'b0;
      bg_latch_q <= 1'b0;
      osc_latch_q <= 1'b0;
    end else if (ce_i) begin
      bg_latch_q <= bg_latch_d;
      osc_latch_q <= osc_latch_d;
      if (psm_reset_i) begin
        bg_load_q <= 1'b0;
        osc_load_q <= 1'b0;
      end else begin
        if (wr_acc && sel_bg) begin
          bg_load_q <= pwdata_i[FUSE_LOAD_BIT];
        end
        if (wr_acc && sel_osc && unlocked) begin
          osc_load_q <= pwdata_i[FUSE_LOAD_BIT];
        end
      end
    end
  end

  assign bandgap_fuse_load_o = bg_load_q;
  assign osc_fuse_load_o = osc_load_q;
  assign bandgap_trim_latch_o = bg_latch_q;
  assign osc_trim_latch_o = osc_latch_q;

  // ****************************************************************
  // Hibernate control of regulator 4
  // ****************************************************************
  // Trigger source chosen by the select field.
  always_comb begin
    case (sleep_trig_q)
      TRIG_HIB_BIT: hib_now = hib_bit_q;
      2'h1: hib_now = lp_sync[0];
      2'h2: hib_now = lp_sync[1];
      default: hib_now = lp_sync[2];
    endcase
  end

  // Reserved modes leave the regulator as it was: neither override.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_q <= 1'b0;
      use_vimg_q <= 1'b0;
      off_q <= 1'b0;
    end else if (ce_i) begin
      sleep_q <= hib_now;
      use_vimg_q <= hib_now & (sleep_mode_q == MODE_VOLT_IMAGE);
      off_q <= hib_now & (sleep_mode_q == MODE_OUTPUT_OFF);
    end
  end

  assign reg4_sleep_o = sleep_q;
  assign reg4_use_sleep_voltage_o = use_vimg_q;
  assign reg4_output_off_o = off_q;
  assign reg4_sleep_voltage_code_o = sleep_vcode_q;

  // ****************************************************************
  // Supply-fault output
  // ****************************************************************
  // A set mask bit removes that supply from the combined fault.
  assign fault_active = |(fault_sync & ~fault_mask_q & MASK_VALID);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fault_n_q <= 1'b1;
    end else if (ce_i) begin
      fault_n_q <= ~fault_active;
    end
  end

  assign supply_fault_n_o = fault_n_q;

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  assign irq_event[IRQ_FAULT] = fault_active & fault_n_q;
  assign irq_event[IRQ_HIB] = hib_now & ~sleep_q;
  assign irq_event[IRQ_BG_LATCH] = bg_latch_d;
  assign irq_event[IRQ_OSC_LATCH] = osc_latch_d;
  assign irq_event[IRQ_LOCKED] = osc_refused;

  // Write one to clear; a new event in the clearing cycle still sets.
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_acc && sel_stat) begin
      irq_stat_d = irq_stat_q & ~pwdata_i[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_event;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_q & irq_mask_q);
      if (wr_acc && sel_imask) begin
        irq_mask_q <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  assign irq_o = irq_q;

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata = '0;
    if (sel_cfg) begin
      rdata[SLP_MODE_LSB +: 2] = sleep_mode_q;
      rdata[SLP_TRIG_LSB +: 2] = sleep_trig_q;
      rdata[SLP_VCODE_LSB +: 5] = sleep_vcode_q;
    end else if (sel_mask) begin
      rdata = fault_mask_q;
    end else if (sel_bg) begin
      rdata[FUSE_LOAD_BIT] = bg_load_q;
    end else if (sel_osc) begin
      rdata[FUSE_LOAD_BIT] = osc_load_q;
    end else if (sel_key) begin
      rdata = key_q;
    end else if (sel_hib) begin
      rdata[0] = hib_bit_q;
    end else if (sel_stat) begin
      rdata[IRQ_W-1:0] = irq_stat_q;
    end else if (sel_imask) begin
      rdata[IRQ_W-1:0] = irq_mask_q;
    end else if (sel_fstat) begin
      rdata = fault_sync & MASK_VALID;
    end
  end

  // Read data and error are captured in the setup phase, so the access
  // phase always completes in one cycle.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else if (ce_i) begin
      if (psel_i && !penable_i) begin
        prdata_q <= pwrite_i ? '0 : {16'h0000, rdata};
        slverr_q <= ~hit;
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pslverr_o = slverr_q & psel_i & penable_i;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_sleep_psm_defaults: assert property (
    ce_i && psm_reset_i |=> sleep_mode_q == SLP_MODE_RST &&
      sleep_trig_q == SLP_TRIG_RST && sleep_vcode_q == SLP_VCODE_RST)
    else $error("sleep fields not restored by state machine reset");
  a_mask_psm_clear: assert property (
    ce_i && psm_reset_i |=> fault_mask_q == MASK_RST)
    else $error("fault masks not cleared by state machine reset");
  a_mode_volt_image: assert property (
    ce_i && hib_now && sleep_mode_q == MODE_VOLT_IMAGE
      |=> reg4_use_sleep_voltage_o && !reg4_output_off_o)
    else $error("sleep voltage code not selected in hibernate");
  a_mode_output_off: assert property (
    ce_i && hib_now && sleep_mode_q == MODE_OUTPUT_OFF
      |=> reg4_output_off_o && !reg4_use_sleep_voltage_o)
    else $error("regulator not turned off in hibernate");
  a_reserved_no_action: assert property (
    ce_i && sleep_mode_q[1] |=> !reg4_output_off_o &&
      !reg4_use_sleep_voltage_o)
    else $error("reserved sleep behaviour produced an action");
  a_trig_input_two: assert property (
    ce_i && sleep_trig_q == 2'h2 |=> reg4_sleep_o == $past(lp_sync[1]))
    else $error("trigger select did not follow low-power input two");
  a_vcode_write: assert property (
    ce_i && !psm_reset_i && wr_acc && sel_cfg
      |=> reg4_sleep_voltage_code_o == $past(pwdata_i[4:0]))
    else $error("sleep voltage code not stored");
  a_mask_bit_layout: assert property (
    ce_i && !psm_reset_i && wr_acc && sel_mask
      |=> fault_mask_q[MASK_LS_BIT] == $past(pwdata_i[15]) &&
      fault_mask_q[MASK_LIN_LSB +: 4] == $past(pwdata_i[11:8]) &&
      fault_mask_q[MASK_CONV_LSB +: 6] == $past(pwdata_i[5:0]))
    else $error("fault mask bits stored at wrong positions");
  a_fault_masked_high: assert property (
    ce_i && (fault_sync & ~fault_mask_q & MASK_VALID) == 16'h0000
      |=> supply_fault_n_o)
    else $error("supply-fault output low with all faults masked");
  a_fault_unmasked_low: assert property (
    ce_i && fault_active |=> !supply_fault_n_o)
    else $error("supply-fault output high with unmasked fault");
  a_osc_locked_ignore: assert property (
    ce_i && !psm_reset_i && wr_acc && sel_osc && key_q != UNLOCK_VALUE
      |=> $stable(osc_fuse_load_o) && irq_stat_q[IRQ_LOCKED])
    else $error("locked oscillator fuse-load write took effect");
  a_bg_latch_pulse: assert property (
    $rose(bandgap_trim_latch_o) |-> !bandgap_fuse_load_o &&
      $past(bandgap_fuse_load_o))
    else $error("bandgap trim latched without a set-then-clear");

  c_hib_off: cover property (reg4_output_off_o);
  c_fault_low: cover property ($fell(supply_fault_n_o));
  c_osc_latch: cover property (osc_trim_latch_o);
  c_irq_raise: cover property ($rose(irq_o));

endmodule : rlp_regs

// ### tb/regulator_lowpower_fault_mask_regs_test.sv
// Testbench: self-checking run of the sleep, fault-mask and fuse bank.
`timescale 1ns/1ps
module regulator_lowpower_fault_mask_regs_test;
  import rlp_pkg::*;
  logic clk_sys_i;
  logic rst_i = 1'b1;
  logic psm = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic perr;
  logic [15:0] sf = 16'h0000;
  logic lp1 = 1'b0;
  logic lp2 = 1'b0;
  logic lp3 = 1'b0;
  logic fault_n, sleep, use_v, off, bg_load, bg_lat, osc_load, osc_lat, irq;
  logic [4:0] vcode;
  logic [15:0] seed = 16'h1831;
  logic ce = 1'b1;
  logic [15:0] m;
  logic [4:0] v;
  int err_total = 0;
  int n_checks = 0;

  rlp_regs DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
    .psm_reset_i(psm), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .supply_fault_i(sf), .low_power_input_one_i(lp1),
    .low_power_input_two_i(lp2), .low_power_input_three_i(lp3),
    .supply_fault_n_o(fault_n), .reg4_sleep_o(sleep),
    .reg4_use_sleep_voltage_o(use_v), .reg4_output_off_o(off),
    .reg4_sleep_voltage_code_o(vcode), .bandgap_fuse_load_o(bg_load),
    .bandgap_trim_latch_o(bg_lat), .osc_fuse_load_o(osc_load),
    .osc_trim_latch_o(osc_lat), .irq_o(irq));

  // 4 ns period; the half period is toggled here.
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Output is low only for a fault whose mask bit is clear.
  function automatic logic fault_exp(input logic [15:0] f, m);
    return !(|(f & ~m & MASK_VALID));
  endfunction : fault_exp

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt

  // The request is held until pready is seen high, never assumed.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [15:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready !== 1'b1 && k < 8);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [31:0] q;
    apb(1'b1, ad(i), d, q);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [31:0] k, e);
    logic [31:0] q;
    apb(1'b0, ad(i), 16'h0000, q);
    chk(q & k, e);
  endtask : rd

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] q;
    wt(2);
    rst_i <= 1'b0;
    wt(1);
    chk(vcode, 5'h1C);
    rd(IDX_SLEEP_CFG, 32'hFFFF, 32'h001C);
    rd(IDX_FAULT_MASK, 32'hFFFF, 32'h0);
    // Each mask bit alone; reserved positions must never pull low.
    for (int i = 0; i < 16; i++) begin
      sf <= 16'(1 << i);
      wr(IDX_FAULT_MASK, 16'h0000);
      wt(5);
      chk(fault_n, !MASK_VALID[i]);
      wr(IDX_FAULT_MASK, 16'(1 << i));
      wt(3);
      chk(fault_n, 1'b1);
    end
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      m = seed;
      seed = lfsr(seed);
      sf <= seed;
      wr(IDX_FAULT_MASK, m);
      wt(5);
      rd(IDX_FAULT_MASK, 32'hFFFF, {16'h0, m & MASK_VALID});
      chk(fault_n, fault_exp(seed, m));
      rd(IDX_FAULT_STAT, 32'hFFFF, {16'h0, seed & MASK_VALID});
    end
    // With the clock enable low the output must not follow the pins.
    ce <= 1'b0;
    sf <= 16'h0000;
    wt(5);
    chk(fault_n, fault_exp(seed, m));
    ce <= 1'b1;
    sf <= 16'h0000;
    // Every behaviour code, reserved ones included, under the hib bit.
    for (int b = 0; b < 4; b++) begin
      seed = lfsr(seed);
      v = seed[4:0];
      wr(IDX_SLEEP_CFG, {2'h0, 2'(b), 7'h00, v});
      wr(IDX_HIB_CTRL, 16'h0001);
      wt(3);
      chk(sleep, 1'b1);
      chk(use_v, b == 0);
      chk(off, b == 1);
      chk(vcode, v);
      rd(IDX_SLEEP_CFG, 32'hFFFF, {18'h0, 2'(b), 7'h00, v});
      wr(IDX_HIB_CTRL, 16'h0000);
    end
    for (int t = 1; t < 4; t++) begin
      wr(IDX_SLEEP_CFG, {6'h00, 2'(t), 8'h00});
      {lp3, lp2, lp1} <= 3'(1 << (t - 1));
      wt(5);
      chk(sleep, 1'b1);
      {lp3, lp2, lp1} <= ~3'(1 << (t - 1));
      wt(5);
      chk(sleep, 1'b0);
    end
    {lp3, lp2, lp1} <= 3'b000;
    wr(IDX_FAULT_MASK, 16'hFFFF);
    psm <= 1'b1;
    wt(1);
    psm <= 1'b0;
    rd(IDX_SLEEP_CFG, 32'hFFFF, 32'h001C);
    rd(IDX_FAULT_MASK, 32'hFFFF, 32'h0);
    apb(1'b0, 12'h004, 16'h0000, q);
    chk(perr, 1'b1);
    apb(1'b1, 12'h34E, 16'hFFFF, q);
    chk(perr, 1'b1);
    rd(IDX_SLEEP_CFG, 32'hFFFF, 32'h001C);
    // Fuse load set then cleared must latch trim and raise the irq.
    wr(IDX_IRQ_STAT, 16'h001F);
    wr(IDX_IRQ_MASK, 16'h0004);
    wr(IDX_BANDGAP, 16'h8000);
    wt(2);
    chk(bg_load, 1'b1);
    chk(irq, 1'b0);
    wr(IDX_BANDGAP, 16'h0000);
    wt(2);
    chk(irq, 1'b1);
    rd(IDX_IRQ_STAT, 32'h4, 32'h4);
    wr(IDX_IRQ_STAT, 16'h0004);
    wt(2);
    chk(irq, 1'b0);
    wr(IDX_IRQ_MASK, 16'h0018);
    wr(IDX_OSC, 16'h8000);
    wt(2);
    chk(osc_load, 1'b0);
    chk(irq, 1'b1);
    wr(IDX_IRQ_STAT, 16'h0010);
    wt(2);
    chk(irq, 1'b0);
    wr(IDX_UNLOCK_KEY, UNLOCK_VALUE);
    wr(IDX_OSC, 16'h8000);
    wt(2);
    chk(osc_load, 1'b1);
    wr(IDX_OSC, 16'h0000);
    wt(2);
    rd(IDX_IRQ_STAT, 32'h18, 32'h8);
    complete_run();
  end
endmodule : regulator_lowpower_fault_mask_regs_test
